//--- rtl/xie_params.svh
/*
  Constants for the extended instruction execute block: field widths,
  reset values and the cycle counts of a skipping instruction.
  Assumes inclusion by bare name from the design files.
*/
`ifndef XIE_PARAMS_SVH
`define XIE_PARAMS_SVH
`define XIE_DATA_W 8
`define XIE_ADDR_W 16
`define XIE_PADDR_W 16
`define XIE_ACC_RST 8'h00
`define XIE_LATCH_HI_RST 8'h00
`define XIE_PTR_LO_RST 8'h00
`define XIE_PTR_HI_RST 8'h00
`define XIE_ALL_ONES 8'hff
`define XIE_LAST_PAGE 8'hff
`define XIE_SKIP_CYCLES 3
`define XIE_FLAG_C 0
`define XIE_FLAG_AUX 1
`define XIE_FLAG_Z 2
`define XIE_FLAG_OVF 3
`define XIE_FLAG_SGN 4
`define XIE_FLAG_CMPZ 5
`define XIE_FLAGS_RST 6'h00
`endif

//--- rtl/xie_pkg.sv
/*
  Types for the extended instruction execute block: operation codes,
  flag bundle and the instruction request carrier.
  Assumes the core decoder has already mapped opcodes onto xie_op_t.
*/
package xie_pkg;
  typedef enum logic [4:0] {
    XIE_NOP, XIE_ROT_R_MEM, XIE_ROT_R_ACC, XIE_ROT_RC_MEM, XIE_ROT_RC_ACC,
    XIE_SUBB_ACC, XIE_SUBB_MEM, XIE_SUB_ACC, XIE_SUB_MEM,
    XIE_DEC_SKZ_MEM, XIE_DEC_SKZ_ACC, XIE_INC_SKZ_MEM, XIE_INC_SKZ_ACC,
    XIE_SET_BYTE, XIE_SET_BIT, XIE_SKIP_BIT_SET, XIE_SKIP_BIT_CLR,
    XIE_SKIP_NZ, XIE_SKIP_Z, XIE_COPY_SKZ, XIE_SWAP_MEM, XIE_SWAP_ACC,
    XIE_TRD_PAGE, XIE_TRD_LAST, XIE_TRD_PAGE_INC, XIE_TRD_LAST_INC,
    XIE_XOR_ACC, XIE_XOR_MEM
  } xie_op_t;

  typedef struct packed {
    logic compare_zero_flag;
    logic signed_compare_flag;
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } xie_flags_t;

  typedef struct packed {
    xie_op_t op;
    logic [15:0] addr;
    logic [2:0] bit_sel;
  } xie_req_t;
endpackage : xie_pkg

//--- rtl/xie_alu.sv
/*
  Combinational arithmetic and logic core of the extended execute block.
  Assumes stable operands: registered values from the sequencer and mem from the data memory read data.
*/
`timescale 1ns/10ps
`include "xie_params.svh"
module xie_alu (
  input wire xie_pkg::xie_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire logic [2:0] bit_sel,
  input wire xie_pkg::xie_flags_t flags_in,
  output logic [7:0] result,
  output xie_pkg::xie_flags_t flags_out,
  output logic skip
);
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic borrow_in;

  // Result, flags and skip condition per operation.
  always_comb begin
    result = mem;
    flags_out = flags_in;
    skip = 1'b0;
    borrow_in = 1'b0;
    if (op == xie_pkg::XIE_SUBB_ACC || op == xie_pkg::XIE_SUBB_MEM) begin
      borrow_in = ~flags_in.carry_flag;
    end
    diff = {1'b0, acc} - {1'b0, mem} - {8'h00, borrow_in};
    low_diff = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, borrow_in};
    case (op)
      xie_pkg::XIE_ROT_R_MEM, xie_pkg::XIE_ROT_R_ACC: begin
        result = {mem[0], mem[7:1]};
      end
      xie_pkg::XIE_ROT_RC_MEM, xie_pkg::XIE_ROT_RC_ACC: begin
        result = {flags_in.carry_flag, mem[7:1]};
        flags_out.carry_flag = mem[0];
      end
      xie_pkg::XIE_SUBB_ACC, xie_pkg::XIE_SUBB_MEM,
      xie_pkg::XIE_SUB_ACC, xie_pkg::XIE_SUB_MEM: begin
        result = diff[7:0];
        flags_out.carry_flag = ~diff[8];
        flags_out.aux_carry_flag = ~low_diff[4];
        flags_out.zero_flag = (diff[7:0] == 8'h00);
        flags_out.overflow_flag = (acc[7] ^ mem[7]) & (acc[7] ^ diff[7]);
        flags_out.signed_compare_flag = diff[7] ^ flags_out.overflow_flag;
        flags_out.compare_zero_flag = (diff[7:0] == 8'h00);
      end
      xie_pkg::XIE_DEC_SKZ_MEM, xie_pkg::XIE_DEC_SKZ_ACC: begin
        result = mem - 8'h01;
        skip = (result == 8'h00);
      end
      xie_pkg::XIE_INC_SKZ_MEM, xie_pkg::XIE_INC_SKZ_ACC: begin
        result = mem + 8'h01;
        skip = (result == 8'h00);
      end
      xie_pkg::XIE_SET_BYTE: begin
        result = `XIE_ALL_ONES;
      end
      xie_pkg::XIE_SET_BIT: begin
        result = mem | (8'h01 << bit_sel);
      end
      xie_pkg::XIE_SKIP_BIT_SET: skip = mem[bit_sel];
      xie_pkg::XIE_SKIP_BIT_CLR: skip = ~mem[bit_sel];
      xie_pkg::XIE_SKIP_NZ: skip = (mem != 8'h00);
      xie_pkg::XIE_SKIP_Z: skip = (mem == 8'h00);
      xie_pkg::XIE_COPY_SKZ: skip = (mem == 8'h00);
      xie_pkg::XIE_SWAP_MEM, xie_pkg::XIE_SWAP_ACC: begin
        result = {mem[3:0], mem[7:4]};
      end
      xie_pkg::XIE_XOR_ACC, xie_pkg::XIE_XOR_MEM: begin
        result = acc ^ mem;
        flags_out.zero_flag = (result == 8'h00);
      end
      default: begin
        result = mem;
      end
    endcase
  end
endmodule : xie_alu

//--- rtl/xie_table_addr.sv
/*
  Table read address former: picks the page and the optionally
  pre-incremented low pointer for program memory table reads.
  Assumes the program memory answers one cycle after an address is given.
*/
`timescale 1ns/10ps
`include "xie_params.svh"
module xie_table_addr (
  input wire logic last_page,
  input wire logic pre_inc,
  input wire logic [7:0] ptr_low,
  input wire logic [7:0] ptr_high,
  output logic [7:0] ptr_low_new,
  output logic [15:0] prog_addr
);
  // The low pointer wraps inside its page; the high pointer never carries.
  always_comb begin
    ptr_low_new = pre_inc ? ptr_low + 8'h01 : ptr_low;
    prog_addr = {last_page ? `XIE_LAST_PAGE : ptr_high, ptr_low_new};
  end
endmodule : xie_table_addr

//--- rtl/xie_exec.sv
/*
  Extended instruction execute sequencer: reads the operand at a full
  data address, runs the operation, writes memory or accumulator, updates
  flags and the table latch, and swallows the next instruction on a skip.
  Assumes synchronous data and program memories with one cycle of read
  latency, and a core that holds the request until done is pulsed.
*/
`timescale 1ns/10ps
`include "xie_params.svh"
module xie_exec (
  input wire logic clock,
  input wire logic reset,
  input wire logic req_valid,
  input wire xie_pkg::xie_req_t req,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] prog_rdata,
  output logic done,
  output logic skip_taken,
  output logic mem_re,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic prog_re,
  output logic [15:0] prog_addr,
  output logic [7:0] acc,
  output xie_pkg::xie_flags_t flags,
  output logic [7:0] table_high_latch,
  output logic [7:0] table_pointer_low,
  output logic [7:0] table_pointer_high,
  input wire logic tp_low_we,
  input wire logic tp_high_we,
  input wire logic [7:0] tp_wdata,
  input wire logic acc_we,
  input wire logic [7:0] acc_wdata
);
  typedef enum logic [2:0] {
    XIE_IDLE, XIE_READ, XIE_EXEC, XIE_TREAD, XIE_TWRITE, XIE_DUMMY, XIE_DONE
  } xie_state_t;

  xie_state_t state_reg, state_next;
  xie_pkg::xie_req_t cur_reg, cur_next;
  logic [7:0] acc_reg, acc_next;
  xie_pkg::xie_flags_t flags_reg, flags_next;
  logic [7:0] latch_hi_reg, latch_hi_next;
  logic [7:0] ptr_lo_reg, ptr_lo_next;
  logic [7:0] ptr_hi_reg, ptr_hi_next;
  logic done_reg, done_next;
  logic skip_reg, skip_next;
  logic mem_re_reg, mem_re_next;
  logic mem_we_reg, mem_we_next;
  logic [15:0] mem_addr_reg, mem_addr_next;
  logic [7:0] mem_wdata_reg, mem_wdata_next;
  logic prog_re_reg, prog_re_next;
  logic [15:0] prog_addr_reg, prog_addr_next;
  logic [7:0] alu_result;
  xie_pkg::xie_flags_t alu_flags;
  logic alu_skip;
  logic [7:0] tp_low_new;
  logic [15:0] tp_addr;
  logic is_table, is_last, is_inc, to_acc, to_mem;

  xie_alu u_alu (
    .op(cur_reg.op),
    .acc(acc_reg),
    .mem(mem_rdata),
    .bit_sel(cur_reg.bit_sel),
    .flags_in(flags_reg),
    .result(alu_result),
    .flags_out(alu_flags),
    .skip(alu_skip)
  );

  xie_table_addr u_taddr (
    .last_page(is_last),
    .pre_inc(is_inc),
    .ptr_low(ptr_lo_reg),
    .ptr_high(ptr_hi_reg),
    .ptr_low_new(tp_low_new),
    .prog_addr(tp_addr)
  );

  // Operation class decode of the latched request.
  always_comb begin
    is_table = cur_reg.op inside {xie_pkg::XIE_TRD_PAGE, xie_pkg::XIE_TRD_LAST,
                                  xie_pkg::XIE_TRD_PAGE_INC, xie_pkg::XIE_TRD_LAST_INC};
    is_last = cur_reg.op inside {xie_pkg::XIE_TRD_LAST, xie_pkg::XIE_TRD_LAST_INC};
    is_inc = cur_reg.op inside {xie_pkg::XIE_TRD_PAGE_INC, xie_pkg::XIE_TRD_LAST_INC};
    to_acc = cur_reg.op inside {xie_pkg::XIE_ROT_R_ACC, xie_pkg::XIE_ROT_RC_ACC,
                                xie_pkg::XIE_SUBB_ACC, xie_pkg::XIE_SUB_ACC,
                                xie_pkg::XIE_DEC_SKZ_ACC, xie_pkg::XIE_INC_SKZ_ACC,
                                xie_pkg::XIE_COPY_SKZ, xie_pkg::XIE_SWAP_ACC,
                                xie_pkg::XIE_XOR_ACC};
    // Skip-on-bit tests leave memory alone; XIE_SKIP_NZ and XIE_SKIP_Z rewrite it, XIE_COPY_SKZ writes the accumulator.
    to_mem = !to_acc && !is_table &&
             !(cur_reg.op inside {xie_pkg::XIE_NOP, xie_pkg::XIE_SKIP_BIT_SET,
                                  xie_pkg::XIE_SKIP_BIT_CLR});
  end

  // Sequencer next state: read, then either execute with optional dummy or table read and write, then done.
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    acc_next = acc_reg;
    flags_next = flags_reg;
    latch_hi_next = latch_hi_reg;
    ptr_lo_next = ptr_lo_reg;
    ptr_hi_next = ptr_hi_reg;
    done_next = 1'b0;
    skip_next = skip_reg;
    mem_re_next = 1'b0;
    mem_we_next = 1'b0;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    prog_re_next = 1'b0;
    prog_addr_next = prog_addr_reg;
    if (tp_low_we) begin
      ptr_lo_next = tp_wdata;
    end
    if (tp_high_we) begin
      ptr_hi_next = tp_wdata;
    end
    if (acc_we) begin
      acc_next = acc_wdata;
    end
    case (state_reg)
      XIE_IDLE: begin
        if (req_valid) begin
          cur_next = req;
          skip_next = 1'b0;
          // A request arriving while a skip is pending is swallowed whole.
          if (skip_reg) begin
            cur_next.op = xie_pkg::XIE_NOP;
          end
          mem_addr_next = req.addr;
          mem_re_next = !skip_reg;
          state_next = skip_reg ? XIE_DONE : XIE_READ;
        end
      end
      XIE_READ: begin
        state_next = XIE_EXEC;
        if (is_table) begin
          ptr_lo_next = tp_low_new;
          prog_addr_next = tp_addr;
          prog_re_next = 1'b1;
          state_next = XIE_TREAD;
        end
      end
      XIE_EXEC: begin
        flags_next = alu_flags;
        if (to_acc) begin
          acc_next = alu_result;
        end
        mem_we_next = to_mem;
        mem_wdata_next = alu_result;
        skip_next = alu_skip;
        state_next = alu_skip ? XIE_DUMMY : XIE_DONE;
      end
      XIE_TREAD: begin
        state_next = XIE_TWRITE;
      end
      XIE_TWRITE: begin
        mem_wdata_next = prog_rdata[7:0];
        latch_hi_next = prog_rdata[15:8];
        mem_we_next = 1'b1;
        state_next = XIE_DONE;
      end
      XIE_DUMMY: begin
        state_next = XIE_DONE;
      end
      XIE_DONE: begin
        done_next = 1'b1;
        state_next = XIE_IDLE;
      end
      default: begin
        state_next = XIE_IDLE;
      end
    endcase
  end

  // All state and every output register; reset gives a quiet idle block.
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= XIE_IDLE;
      cur_reg <= '0;
      acc_reg <= `XIE_ACC_RST;
      flags_reg <= `XIE_FLAGS_RST;
      latch_hi_reg <= `XIE_LATCH_HI_RST;
      ptr_lo_reg <= `XIE_PTR_LO_RST;
      ptr_hi_reg <= `XIE_PTR_HI_RST;
      done_reg <= 1'b0;
      skip_reg <= 1'b0;
      mem_re_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 8'h00;
      prog_re_reg <= 1'b0;
      prog_addr_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      latch_hi_reg <= latch_hi_next;
      ptr_lo_reg <= ptr_lo_next;
      ptr_hi_reg <= ptr_hi_next;
      done_reg <= done_next;
      skip_reg <= skip_next;
      mem_re_reg <= mem_re_next;
      mem_we_reg <= mem_we_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      prog_re_reg <= prog_re_next;
      prog_addr_reg <= prog_addr_next;
    end
  end

  assign done = done_reg;
  assign skip_taken = skip_reg;
  assign mem_re = mem_re_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign prog_re = prog_re_reg;
  assign prog_addr = prog_addr_reg;
  assign acc = acc_reg;
  assign flags = flags_reg;
  assign table_high_latch = latch_hi_reg;
  assign table_pointer_low = ptr_lo_reg;
  assign table_pointer_high = ptr_hi_reg;

  // A write pulse always carries the latched operand address.
  sequence exec_step_s;
    state_reg == XIE_EXEC;
  endsequence
  write_addr_a: assert property (@(posedge clock) disable iff (reset)
    mem_we_reg |-> mem_addr_reg == cur_reg.addr)
    else $error("memory write to wrong address");
  skip_dummy_a: assert property (@(posedge clock) disable iff (reset)
    exec_step_s ##0 alu_skip |=> state_reg == XIE_DUMMY ##1 state_reg == XIE_DONE)
    else $error("skip did not insert dummy cycle");
  acc_form_a: assert property (@(posedge clock) disable iff (reset)
    exec_step_s ##0 to_acc |=> !mem_we_reg)
    else $error("accumulator form wrote memory");
  sub_carry_a: assert property (@(posedge clock) disable iff (reset)
    exec_step_s ##0 (cur_reg.op == xie_pkg::XIE_SUB_ACC)
      |=> flags_reg.carry_flag == ($past(acc_reg) >= $past(mem_rdata)))
    else $error("subtract carry wrong");
  flags_hold_a: assert property (@(posedge clock) disable iff (reset)
    exec_step_s ##0 (cur_reg.op inside {xie_pkg::XIE_SET_BYTE, xie_pkg::XIE_SWAP_MEM})
      |=> $stable(flags_reg))
    else $error("flags changed by flagless op");
  rot_result_a: assert property (@(posedge clock) disable iff (reset)
    exec_step_s ##0 (cur_reg.op == xie_pkg::XIE_ROT_R_MEM)
      |=> mem_wdata_reg == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
    else $error("rotate right result wrong");
  skipped_nop_a: assert property (@(posedge clock) disable iff (reset)
    (state_reg == XIE_IDLE && req_valid && skip_reg)
      |=> !mem_re_reg ##1 (!mem_we_reg && done_reg))
    else $error("skipped instruction had effect");
  table_latch_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == XIE_TWRITE |=> latch_hi_reg == $past(prog_rdata[15:8]) && mem_we_reg)
    else $error("table read latch wrong");
  last_page_a: assert property (@(posedge clock) disable iff (reset)
    (prog_re_reg && is_last) |-> prog_addr_reg[15:8] == `XIE_LAST_PAGE)
    else $error("last page address wrong");
endmodule : xie_exec

//--- testbench/extended_instruction_execute_tb_top.sv
/*
  Self-checking testbench for the extended instruction execute sequencer.
  Assumes the package and design files are compiled first; the bench plays
  the core, the data memory and the program memory at the falling edge.
*/
`timescale 1ns/10ps
module extended_instruction_execute_tb_top;
  typedef struct packed {
    logic [7:0] acc;
    xie_pkg::xie_flags_t flags;
    logic wr;
    logic [7:0] wdata;
    logic skip;
  } xie_exp_t;

  logic clock, reset, req_valid, tp_low_we, tp_high_we, acc_we;
  logic done, skip_taken, mem_re, mem_we, prog_re;
  xie_pkg::xie_req_t req;
  xie_pkg::xie_flags_t flags, e_flags;
  logic [7:0] mem_rdata, tp_wdata, acc_wdata, acc, mem_wdata, table_high_latch;
  logic [7:0] table_pointer_low, table_pointer_high, cur_mem, w_data, e_acc, e_tpl, e_tph;
  logic [15:0] prog_rdata, mem_addr, prog_addr, w_addr, re_addr, p_addr;
  int error_cnt, cmp_count, n_re, n_we, n_pre, base_lat;
  logic re_d, pre_d;

  xie_exec uut (
    .clock(clock), .reset(reset), .req_valid(req_valid), .req(req),
    .mem_rdata(mem_rdata), .prog_rdata(prog_rdata), .done(done), .skip_taken(skip_taken),
    .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .prog_re(prog_re), .prog_addr(prog_addr), .acc(acc), .flags(flags),
    .table_high_latch(table_high_latch), .table_pointer_low(table_pointer_low),
    .table_pointer_high(table_pointer_high), .tp_low_we(tp_low_we), .tp_high_we(tp_high_we),
    .tp_wdata(tp_wdata), .acc_we(acc_we), .acc_wdata(acc_wdata)
  );

  // The clock toggles every half period of 20 ns.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Program words are a scramble of their address so a wrong page shows up.
  function automatic logic [15:0] pword(logic [15:0] a);
    return {a[7:0] ^ 8'h5a, a[15:8] + a[7:0]};
  endfunction : pword

  // Memories answer in the cycle after a read strobe, as synchronous memories
  // do; otherwise the lines carry an inverted pattern, so a read sampled in
  // the wrong cycle is caught.
  always @(negedge clock) begin
    mem_rdata <= re_d ? cur_mem : ~cur_mem;
    prog_rdata <= pre_d ? pword(prog_addr) : ~pword(prog_addr);
    re_d <= mem_re;
    pre_d <= prog_re;
    if (mem_re) begin n_re++; re_addr = mem_addr; end
    if (mem_we) begin n_we++; w_addr = mem_addr; w_data = mem_wdata; end
    if (prog_re) begin n_pre++; p_addr = prog_addr; end
  end

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Reference model of one non-table operation on accumulator, operand and flags.
  function automatic xie_exp_t model(xie_pkg::xie_op_t op, logic [7:0] a, logic [7:0] m,
      logic [2:0] b, xie_pkg::xie_flags_t f);
    xie_exp_t e;
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] r;
    logic ci;
    ci = (op == xie_pkg::XIE_SUBB_ACC || op == xie_pkg::XIE_SUBB_MEM) ? f.carry_flag : 1'b1;
    d = {1'b0, a} + {1'b0, ~m} + 9'(ci);
    h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'(ci);
    r = m;
    e = '{a, f, 1'b0, m, 1'b0};
    case (op)
      xie_pkg::XIE_ROT_R_MEM, xie_pkg::XIE_ROT_R_ACC: r = {m[0], m[7:1]};
      xie_pkg::XIE_ROT_RC_MEM, xie_pkg::XIE_ROT_RC_ACC: begin
        r = {f.carry_flag, m[7:1]};
        e.flags.carry_flag = m[0];
      end
      xie_pkg::XIE_SUBB_ACC, xie_pkg::XIE_SUBB_MEM, xie_pkg::XIE_SUB_ACC,
      xie_pkg::XIE_SUB_MEM: begin
        r = d[7:0];
        e.flags.carry_flag = d[8];
        e.flags.aux_carry_flag = h[4];
        e.flags.overflow_flag = (a[7] ^ m[7]) & (r[7] ^ a[7]);
        e.flags.signed_compare_flag = r[7] ^ e.flags.overflow_flag;
        e.flags.zero_flag = (r == 8'h00);
        e.flags.compare_zero_flag = (r == 8'h00);
      end
      xie_pkg::XIE_DEC_SKZ_MEM, xie_pkg::XIE_DEC_SKZ_ACC: begin
        r = m - 8'h01;
        e.skip = (r == 8'h00);
      end
      xie_pkg::XIE_INC_SKZ_MEM, xie_pkg::XIE_INC_SKZ_ACC: begin
        r = m + 8'h01;
        e.skip = (r == 8'h00);
      end
      xie_pkg::XIE_SET_BYTE: r = 8'hff;
      xie_pkg::XIE_SET_BIT: r = m | (8'h01 << b);
      xie_pkg::XIE_SKIP_BIT_SET: e.skip = m[b];
      xie_pkg::XIE_SKIP_BIT_CLR: e.skip = ~m[b];
      xie_pkg::XIE_SKIP_NZ: e.skip = (m != 8'h00);
      xie_pkg::XIE_SKIP_Z, xie_pkg::XIE_COPY_SKZ: e.skip = (m == 8'h00);
      xie_pkg::XIE_SWAP_MEM, xie_pkg::XIE_SWAP_ACC: r = {m[3:0], m[7:4]};
      xie_pkg::XIE_XOR_ACC, xie_pkg::XIE_XOR_MEM: begin
        r = a ^ m;
        e.flags.zero_flag = (r == 8'h00);
      end
      default: ;
    endcase
    if (op inside {xie_pkg::XIE_ROT_R_ACC, xie_pkg::XIE_ROT_RC_ACC, xie_pkg::XIE_SUBB_ACC,
        xie_pkg::XIE_SUB_ACC, xie_pkg::XIE_DEC_SKZ_ACC, xie_pkg::XIE_INC_SKZ_ACC,
        xie_pkg::XIE_COPY_SKZ, xie_pkg::XIE_SWAP_ACC, xie_pkg::XIE_XOR_ACC}) e.acc = r;
    if (op inside {xie_pkg::XIE_ROT_R_MEM, xie_pkg::XIE_ROT_RC_MEM, xie_pkg::XIE_SUBB_MEM,
        xie_pkg::XIE_SUB_MEM, xie_pkg::XIE_DEC_SKZ_MEM, xie_pkg::XIE_INC_SKZ_MEM,
        xie_pkg::XIE_SET_BYTE, xie_pkg::XIE_SET_BIT, xie_pkg::XIE_SKIP_NZ, xie_pkg::XIE_SKIP_Z,
        xie_pkg::XIE_SWAP_MEM, xie_pkg::XIE_XOR_MEM}) begin
      e.wr = 1'b1;
      e.wdata = r;
    end
    return e;
  endfunction : model

  task automatic do_reset();
    reset = 1'b1;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    {e_acc, e_flags, e_tpl, e_tph} = '0;
    chk("acc", 16'h0000, acc);
    chk("flags", 16'h0000, flags);
    chk("table high", 16'h0000, table_high_latch);
    chk("pointer low", 16'h0000, table_pointer_low);
    chk("pointer high", 16'h0000, table_pointer_high);
  endtask : do_reset

  // Core writes: accumulator and pointer low in one cycle, pointer high in the next; pointers share tp_wdata.
  task automatic preset(logic [7:0] a, logic [7:0] pl, logic [7:0] ph);
    acc_we = 1'b1; acc_wdata = a; tp_low_we = 1'b1; tp_wdata = pl;
    @(negedge clock);
    acc_we = 1'b0; tp_low_we = 1'b0; tp_high_we = 1'b1; tp_wdata = ph;
    @(negedge clock);
    tp_high_we = 1'b0;
    e_acc = a; e_tpl = pl; e_tph = ph;
  endtask : preset

  // The request is held until done, then dropped; one idle cycle follows.
  task automatic issue(xie_pkg::xie_req_t r, output int lat);
    n_re = 0; n_we = 0; n_pre = 0; lat = 0;
    req = r; req_valid = 1'b1;
    do begin
      @(negedge clock);
      lat++;
    end while (done !== 1'b1 && lat < 50);
    req_valid = 1'b0;
    req = xie_pkg::xie_req_t'(24'($urandom));
    @(negedge clock);
    chk("done pulse", 16'h0000, done);
  endtask : issue

  task automatic run_op(xie_pkg::xie_op_t op, logic [15:0] addr, logic [7:0] m, logic [2:0] b);
    xie_exp_t e;
    xie_pkg::xie_req_t rq;
    int lat;
    logic tbl;
    logic [15:0] pa, pw;
    tbl = op inside {xie_pkg::XIE_TRD_PAGE, xie_pkg::XIE_TRD_LAST, xie_pkg::XIE_TRD_PAGE_INC,
        xie_pkg::XIE_TRD_LAST_INC};
    cur_mem = m;
    e = model(op, e_acc, m, b, e_flags);
    issue('{op, addr, b}, lat);
    if (tbl) begin
      e_tpl = e_tpl + 8'(op inside {xie_pkg::XIE_TRD_PAGE_INC, xie_pkg::XIE_TRD_LAST_INC});
      pa = {(op inside {xie_pkg::XIE_TRD_LAST, xie_pkg::XIE_TRD_LAST_INC}) ? 8'hff : e_tph, e_tpl};
      pw = pword(pa);
      e = '{e_acc, e_flags, 1'b1, pw[7:0], 1'b0};
      chk("prog addr", pa, p_addr);
      chk("table high", pw[15:8], table_high_latch);
    end else begin
      chk("reads", 16'h0001, 16'(n_re));
      chk("read addr", addr, re_addr);
    end
    chk("prog reads", 16'(tbl), 16'(n_pre));
    chk("acc", e.acc, acc);
    chk("flags", 16'(e.flags), 16'(flags));
    chk("writes", 16'(e.wr), 16'(n_we));
    if (e.wr) chk("write data", e.wdata, w_data);
    if (e.wr) chk("write addr", addr, w_addr);
    chk("skip", 16'(e.skip), 16'(skip_taken));
    chk("cycles", 16'(base_lat + int'(e.skip | tbl)), 16'(lat));
    e_acc = e.acc;
    e_flags = e.flags;
    if (e.skip) begin
      // The request after a taken skip must pass with no effect at all.
      cur_mem = 8'($urandom);
      rq = '{xie_pkg::xie_op_t'($urandom_range(27, 1)), 16'($urandom), 3'($urandom)};
      issue(rq, lat);
      chk("nop accesses", 16'h0000, 16'(n_re + n_we + n_pre));
      chk("nop acc", e_acc, acc);
      chk("nop flags", 16'(e_flags), 16'(flags));
      chk("nop cycles", 16'(base_lat - 2), 16'(lat));
    end
    chk("pointer low", e_tpl, table_pointer_low);
    chk("pointer high", e_tph, table_pointer_high);
  endtask : run_op

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // A hang is cut short well beyond the expected run of about 2500 cycles.
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    summarize();
  end

  // Corner table: zero, negative and overflowing subtracts, skip edges, pointer wrap.
  xie_pkg::xie_op_t c_op[14] = '{xie_pkg::XIE_SUB_ACC, xie_pkg::XIE_SUB_MEM,
      xie_pkg::XIE_SUBB_ACC, xie_pkg::XIE_ROT_RC_MEM, xie_pkg::XIE_ROT_RC_ACC,
      xie_pkg::XIE_DEC_SKZ_MEM, xie_pkg::XIE_DEC_SKZ_ACC, xie_pkg::XIE_INC_SKZ_ACC,
      xie_pkg::XIE_SKIP_Z, xie_pkg::XIE_SKIP_NZ, xie_pkg::XIE_COPY_SKZ,
      xie_pkg::XIE_SKIP_BIT_SET, xie_pkg::XIE_SKIP_BIT_CLR, xie_pkg::XIE_TRD_LAST_INC};
  logic [7:0] c_m[14] = '{8'h40, 8'h20, 8'h01, 8'h01, 8'h80, 8'h01, 8'h00, 8'hff, 8'h00,
      8'h00, 8'h00, 8'h80, 8'h7f, 8'h3c};
  logic [7:0] c_a[14] = '{8'h40, 8'h10, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Main sequence: reset, corner cases, a second reset, then random traffic.
  initial begin
    {reset, req_valid, tp_low_we, tp_high_we, acc_we} = 5'h10;
    {tp_wdata, acc_wdata, cur_mem} = '0;
    req = '0;
    // A plain operation is seen done four falling edges after its request.
    base_lat = 4;
    void'($urandom(32'h91ba));
    do_reset();
    $display("test reset done");
    for (int i = 0; i < 14; i++) begin
      if (i < 3) preset(c_a[i], 8'hff, 8'h12);
      run_op(c_op[i], 16'hc000 + 16'(i), c_m[i], 3'h7);
    end
    $display("test corners done");
    do_reset();
    for (int i = 0; i < 400; i++) begin
      if ($urandom_range(3, 0) == 0) preset(8'($urandom), 8'($urandom), 8'($urandom));
      run_op(xie_pkg::xie_op_t'($urandom_range(27, 1)), 16'($urandom), 8'($urandom),
          3'($urandom));
    end
    $display("test random done");
    summarize();
  end
endmodule : extended_instruction_execute_tb_top
